// ### bench/ipei_cpu_model.sv
`timescale 1ns/100ps
// ==========================================================
// cpu sequencer model: answers push and vector fetch requests
module ipei_cpu_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // requests and answer speed
   input  wire logic       stackReq,
   input  wire logic       vecFetch,
   input  wire logic [3:0] delay,
   // answers
   output logic            stackDone,
   output logic            vecDone
);
   logic [1:0]      req;
   logic [1:0]      done_r, done_nxt, fired_r, fired_nxt;
   logic [1:0][3:0] cnt_r, cnt_nxt;

   assign req       = {vecFetch, stackReq};
   assign stackDone = done_r[0];
   assign vecDone   = done_r[1];

   // ==========================================================
   // one pulse per request, delay plus one cycles after the request rises
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         done_nxt[i]  = 1'b0;
         fired_nxt[i] = fired_r[i];
         cnt_nxt[i]   = cnt_r[i];
         if (!req[i]) begin
            fired_nxt[i] = 1'b0;
            cnt_nxt[i]   = 4'h0;
         end else if (!fired_r[i]) begin
            if (cnt_r[i] == delay) begin
               done_nxt[i]  = 1'b1;
               fired_nxt[i] = 1'b1;
            end else begin
               cnt_nxt[i] = cnt_r[i] + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         done_r  <= 2'h0;
         fired_r <= 2'h0;
         cnt_r   <= '0;
      end else begin
         done_r  <= done_nxt;
         fired_r <= fired_nxt;
         cnt_r   <= cnt_nxt;
      end
   end
endmodule : ipei_cpu_model

// ### bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import ipei_pkg::*;
   // ==========================================================
   // signals
   logic                    clk, rst;
   ipei_pkg::ipei_avs_in_type avsIn;
   logic [31:0]             avsReadData, rdData;
   logic [31:0]             lvlReadData, lvlData;
   logic                    avsWaitRequest;
   ipei_pkg::ipei_cpu_in_type cpuIn;
   ipei_pkg::ipei_cpu_out_type cpuOut;
   logic                    extIntN, stackDone, vecDone;
   logic [3:0]              portIntPins, srcReq, delay;
   logic [4:0]              resetSrc;
   logic [5:0]              ctl;
   logic [15:0]             vecTab [5];
   int                      error_cnt, tests_run;
   localparam logic [5:0]   P_BND = 6'h20, P_TRP = 6'h30, P_RET = 6'h08, P_RTB = 6'h28, P_CLI = 6'h02;

   assign cpuIn = {ctl, stackDone, vecDone};

   ipei_ctrl u_ipei_ctrl (.clk(clk), .rst(rst), .avsIn(avsIn), .avsReadData(avsReadData),
      .avsWaitRequest(avsWaitRequest), .cpuIn(cpuIn), .cpuOut(cpuOut), .extIntN(extIntN),
      .portIntPins(portIntPins), .resetSrc(resetSrc), .srcReq(srcReq));

   // level sensitive build, checked through its status register only
   ipei_ctrl #(.LEVEL_SENS(1'h1)) u_ipei_ctrl_lvl (.clk(clk), .rst(rst), .avsIn(avsIn),
      .avsReadData(lvlReadData), .avsWaitRequest(), .cpuIn(cpuIn), .cpuOut(), .extIntN(extIntN),
      .portIntPins(portIntPins), .resetSrc(resetSrc), .srcReq(srcReq));

   ipei_cpu_model u_ipei_cpu_model (.clk(clk), .rst(rst), .stackReq(cpuOut.stackReq),
      .vecFetch(cpuOut.vecFetch), .delay(delay), .stackDone(stackDone), .vecDone(vecDone));

   // ==========================================================
   // reporting
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim

   task automatic expire;
      error_cnt++;
      end_sim();
   endtask : expire

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // ==========================================================
   // register bus and cpu side tasks
   task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata);
      @(posedge clk);
      avsIn.address   <= addr;
      avsIn.writedata <= wdata;
      avsIn.read      <= !wr;
      avsIn.write     <= wr;
      for (int i = 0; i <= 20; i++) begin
         @(posedge clk);
         if (avsWaitRequest === 1'b0) break;
         if (i == 20) expire();
      end
      rdData = avsReadData;
      lvlData = lvlReadData;
      avsIn.read  <= 1'b0;
      avsIn.write <= 1'b0;
   endtask : bus

   task automatic rdchk(input logic [3:0] addr, input logic [31:0] exp);
      bus(1'b0, addr, 32'h0);
      chk(rdData, exp);
   endtask : rdchk

   task automatic pulse(input logic [5:0] p);
      @(posedge clk);
      ctl <= p;
      @(posedge clk);
      ctl <= 6'h0;
   endtask : pulse

   task automatic waitc(input logic vec, input logic lvl);
      for (int i = 0; i <= 40; i++) begin
         if ((vec ? cpuOut.vecFetch : cpuOut.stackReq) === lvl) break;
         if (i == 40) expire();
         @(posedge clk);
      end
   endtask : waitc

   task automatic enter(input logic [5:0] p, input logic [15:0] v);
      pulse(p);
      waitc(1'b0, 1'b1);
      chk(cpuOut.vecAddr, v);
      waitc(1'b1, 1'b1);
      chk(cpuOut.stackReq, 1'b0);
      chk(cpuOut.globalMask, 1'b1);
      waitc(1'b1, 1'b0);
   endtask : enter

   task automatic noentry(input logic [5:0] p);
      pulse(p);
      repeat (4) @(posedge clk);
      chk(cpuOut.stackReq, 1'b0);
   endtask : noentry

   task automatic pins(input logic n, input logic [3:0] p);
      @(posedge clk);
      extIntN     <= n;
      portIntPins <= p;
      repeat (2) @(posedge clk);
   endtask : pins

   // ==========================================================
   // clock, hang guard and main sequence
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      expire();
   end

   initial begin
      rst = 1'b1;
      avsIn = '0;
      avsIn.byteenable = 4'hf;
      ctl = 6'h0;
      extIntN = 1'b1;
      portIntPins = 4'h0;
      resetSrc = 5'h0;
      srcReq = 4'h0;
      delay = 4'h0;
      error_cnt = 0;
      tests_run = 0;
      vecTab = '{16'h1ffa, 16'h1ff8, 16'h1ff6, 16'h1ff4, 16'h1ff2};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rdchk(4'h0, 32'h80);
      rdchk(4'h8, 32'h0);
      pins(1'b0, 4'h0);
      rdchk(4'h0, 32'h88);
      bus(1'b1, 4'h0, 32'h88);
      rdchk(4'h0, 32'h88);
      bus(1'b1, 4'h0, 32'h82);
      rdchk(4'h0, 32'h80);
      chk(lvlData, 32'h88);
      pins(1'b1, 4'h0);
      pins(1'b0, 4'h0);
      rdchk(4'h0, 32'h88);
      noentry(P_BND);
      bus(1'b1, 4'h0, 32'h08);
      pulse(P_CLI);
      noentry(P_BND);
      rdchk(4'h0, 32'h08);
      bus(1'b1, 4'h0, 32'h80);
      delay <= 4'h5;
      enter(P_BND, 16'h1ffa);
      rdchk(4'h0, 32'h80);
      pins(1'b1, 4'h0);
      pins(1'b0, 4'h0);
      rdchk(4'h0, 32'h88);
      srcReq <= 4'hf;
      noentry(P_BND);
      for (int i = 0; i < 5; i++) begin
         delay <= 4'(i);
         enter(P_RTB, vecTab[i]);
         if (i > 0) srcReq[i-1] <= 1'b0;
      end
      enter(P_TRP, 16'h1ffc);
      pins(1'b1, 4'h0);
      pins(1'b0, 4'h0);
      noentry(P_RET);
      enter(P_BND, 16'h1ffa);
      rdchk(4'h4, 32'h0001_0201);
      pins(1'b1, 4'h0);
      pins(1'b1, 4'h1);
      rdchk(4'h0, 32'h88);
      bus(1'b1, 4'h0, 32'h82);
      pins(1'b0, 4'h1);
      pins(1'b0, 4'h3);
      rdchk(4'h0, 32'h80);
      chk(lvlData, 32'h88);
      pins(1'b0, 4'h0);
      pins(1'b0, 4'h4);
      rdchk(4'h0, 32'h80);
      pins(1'b1, 4'h4);
      rdchk(4'h0, 32'h80);
      pins(1'b1, 4'h0);
      pins(1'b1, 4'h8);
      rdchk(4'h0, 32'h88);
      @(posedge clk);
      resetSrc <= 5'h10;
      @(posedge clk);
      resetSrc <= 5'h0;
      waitc(1'b1, 1'b1);
      chk(cpuOut.vecAddr, 16'h1ffe);
      chk(cpuOut.resetEntry, 1'b1);
      waitc(1'b1, 1'b0);
      rdchk(4'h4, 32'h0001_0101);
      end_sim();
   end
endmodule : tb_top

// ### rtl/ipei_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// - maskable interrupts are taken only at instruction boundaries
// - each source fetches its own fixed vector pair
// - pending requests are served in fixed priority order, software trap with instruction
// - running routines are preempted by maskable requests only after they clear the global mask; reset preempts them regardless
// - entry stacks registers, then sets global mask and starts vector fetch in the same cycle
// - return restores stacked registers, including the global mask
// - software trap is taken regardless of global mask or local enables
// - external service blocked by global mask set or external enable clear
// - after each instruction latch tested against mask and enable
// - latch cleared during vector fetch; new request may latch meanwhile
// - build option selects falling edge or falling edge plus low level
// - level mode: request present while any source holds the pin low
// - edge mode: new request only after pin returns high and falls
// - port pins option: rising edge latches shared external request
// - port pins share sensitivity choice; level mode high level latches
// - level mode: request present while any source holds a port pin high
// - edge mode: port request again only after return low and rise
// - any port pin high hides dedicated pin and other port pins
// - dedicated pin low hides all port pins
// - pending flag reflects latch, read only, cleared by reset
// - writing one to clear bit clears pending; reads as zero
// - reset sets the external enable bit
module ipei_ctrl #(
   parameter logic LEVEL_SENS  = 1'h0,
   parameter logic PORT_INT_EN = 1'h1,
   parameter logic WATCHDOG_EN = 1'h1
) (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // register bus
   input  wire ipei_pkg::ipei_avs_in_type     avsIn,
   output logic [31:0]                        avsReadData,
   output logic                               avsWaitRequest,
   // cpu sequencer
   input  wire ipei_pkg::ipei_cpu_in_type     cpuIn,
   output ipei_pkg::ipei_cpu_out_type         cpuOut,
   // interrupt sources
   input  wire logic                          extIntN,
   input  wire logic [3:0]                    portIntPins,
   input  wire logic [4:0]                    resetSrc,
   input  wire logic [3:0]                    srcReq
);
   import ipei_pkg::*;

   // ==========================================================
   // state
   ipei_state_type   state_r,       state_nxt;
   ipei_cpu_out_type cpuOut_r,      cpuOut_nxt;
   logic [2:0]       prio_r,        prio_nxt;
   logic             extLatch_r,    extLatch_nxt;
   logic             extEnable_r,   extEnable_nxt;
   logic             prevComb_r,    prevComb_nxt;
   logic             waitReq_r,     waitReq_nxt;
   logic [31:0]      readData_r,    readData_nxt;

   logic             combN;
   logic             extEvent;
   logic             resetHit;
   logic             effMask;
   logic             takeExt;
   logic [3:0]       takeSrc;
   logic             busAccept;
   logic             clrWrite;
   logic             vecClrExt;

   // ==========================================================
   // pin combining and edge detection
   always_comb begin
      // port high hides the pin; pin low hides the ports
      combN    = extIntN & ~(PORT_INT_EN & (|portIntPins));
      prevComb_nxt = combN;
      if (LEVEL_SENS) begin
         extEvent = ~combN | (prevComb_r & ~combN);
      end else begin
         extEvent = prevComb_r & ~combN;
      end
   end

   // ==========================================================
   // bus slave
   always_comb begin
      busAccept    = (avsIn.read | avsIn.write) & ~waitReq_r;
      clrWrite     = busAccept & avsIn.write & avsIn.byteenable[0] &
                     (avsIn.address == ADDR_STATUS_CTRL) & avsIn.writedata[CTRL_CLR_BIT];
      waitReq_nxt  = ~((avsIn.read | avsIn.write) & waitReq_r);
      readData_nxt = readData_r;
      extEnable_nxt = extEnable_r;
      if ((avsIn.read | avsIn.write) & waitReq_r) begin
         readData_nxt = 32'h0000_0000;
         if (avsIn.read) begin
            case (avsIn.address)
               ADDR_STATUS_CTRL: begin
                  readData_nxt[CTRL_EN_BIT]   = extEnable_r;
                  readData_nxt[CTRL_PEND_BIT] = extLatch_r;
               end
               ADDR_SEQ_STATUS: begin
                  readData_nxt[SEQ_STATE_LSB +: 4] = state_r;
                  readData_nxt[SEQ_PRIO_LSB +: 3]  = prio_r;
                  readData_nxt[SEQ_MASK_BIT]       = cpuOut_r.globalMask;
               end
               default: begin
                  readData_nxt = 32'h0000_0000;
               end
            endcase
         end
      end
      if (busAccept & avsIn.write & avsIn.byteenable[0] & (avsIn.address == ADDR_STATUS_CTRL)) begin
         extEnable_nxt = avsIn.writedata[CTRL_EN_BIT];
      end
   end

   // ==========================================================
   // sequencer decision
   always_comb begin
      resetHit = |(resetSrc & {WATCHDOG_EN, 4'hf});
      effMask  = cpuIn.retExec ? cpuIn.retMask : cpuOut_r.globalMask;
      takeExt  = extLatch_r & extEnable_r & ~effMask;
      takeSrc  = srcReq & {4{~effMask}};
      state_nxt  = state_r;
      prio_nxt   = prio_r;
      cpuOut_nxt = cpuOut_r;
      cpuOut_nxt.resetEntry = 1'h0;
      vecClrExt  = 1'h0;
      if (cpuIn.seiExec) begin
         cpuOut_nxt.globalMask = 1'h1;
      end else if (cpuIn.cliExec) begin
         cpuOut_nxt.globalMask = 1'h0;
      end else if (cpuIn.retExec) begin
         cpuOut_nxt.globalMask = cpuIn.retMask;
      end
      case (state_r)
         ST_IDLE: begin
            if (cpuIn.boundary) begin
               state_nxt = ST_STACK;
               cpuOut_nxt.stackReq = 1'h1;
               if (cpuIn.trapExec) begin
                  cpuOut_nxt.vecAddr = VEC_TRAP;
                  prio_nxt = PRIO_TRAP;
               end else if (takeExt) begin
                  cpuOut_nxt.vecAddr = VEC_EXT;
                  prio_nxt = PRIO_EXT;
               end else if (takeSrc[0]) begin
                  cpuOut_nxt.vecAddr = VEC_CTIMER;
                  prio_nxt = PRIO_CTIMER;
               end else if (takeSrc[1]) begin
                  cpuOut_nxt.vecAddr = VEC_PTIMER;
                  prio_nxt = PRIO_PTIMER;
               end else if (takeSrc[2]) begin
                  cpuOut_nxt.vecAddr = VEC_SERIAL;
                  prio_nxt = PRIO_SERIAL;
               end else if (takeSrc[3]) begin
                  cpuOut_nxt.vecAddr = VEC_ANALOG;
                  prio_nxt = PRIO_ANALOG;
               end else begin
                  state_nxt = ST_IDLE;
                  cpuOut_nxt.stackReq = 1'h0;
               end
            end
         end
         ST_STACK: begin
            if (cpuIn.stackDone) begin
               state_nxt = ST_MASK;
               cpuOut_nxt.stackReq = 1'h0;
            end
         end
         ST_MASK: begin
            state_nxt = ST_VECTOR;
            cpuOut_nxt.globalMask = 1'h1;
            cpuOut_nxt.vecFetch   = 1'h1;
            vecClrExt = (cpuOut_r.vecAddr == VEC_EXT);
         end
         ST_VECTOR: begin
            if (cpuIn.vecDone) begin
               state_nxt = ST_IDLE;
               cpuOut_nxt.vecFetch = 1'h0;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            cpuOut_nxt.stackReq = 1'h0;
            cpuOut_nxt.vecFetch = 1'h0;
         end
      endcase
      if (resetHit) begin
         state_nxt = ST_VECTOR;
         prio_nxt  = PRIO_RESET;
         cpuOut_nxt.stackReq   = 1'h0;
         cpuOut_nxt.vecFetch   = 1'h1;
         cpuOut_nxt.vecAddr    = VEC_RESET;
         cpuOut_nxt.globalMask = 1'h1;
         cpuOut_nxt.resetEntry = 1'h1;
      end
   end

   // ==========================================================
   // external request latch, set wins over clear
   always_comb begin
      extLatch_nxt = extLatch_r;
      if (vecClrExt | clrWrite) begin
         extLatch_nxt = 1'h0;
      end
      if (extEvent) begin
         extLatch_nxt = 1'h1;
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r     <= ST_IDLE;
         cpuOut_r    <= '{stackReq: 1'h0, vecFetch: 1'h0, vecAddr: 16'h0000,
                          globalMask: MASK_RST, resetEntry: 1'h0};
         prio_r      <= 3'h0;
         extLatch_r  <= 1'h0;
         extEnable_r <= CTRL_EN_RST;
         prevComb_r  <= 1'h1;
         waitReq_r   <= 1'h1;
         readData_r  <= 32'h0000_0000;
      end else begin
         state_r     <= state_nxt;
         cpuOut_r    <= cpuOut_nxt;
         prio_r      <= prio_nxt;
         extLatch_r  <= extLatch_nxt;
         extEnable_r <= extEnable_nxt;
         prevComb_r  <= prevComb_nxt;
         waitReq_r   <= waitReq_nxt;
         readData_r  <= readData_nxt;
      end
   end

   assign cpuOut         = cpuOut_r;
   assign avsReadData    = readData_r;
   assign avsWaitRequest = waitReq_r;

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   boundary_only_a: assert property ($rose(cpuOut_r.stackReq) |-> $past(cpuIn.boundary))
      else $error("entry started off an instruction boundary");

   reset_vector_a: assert property (resetHit |=> cpuOut_r.vecFetch && cpuOut_r.vecAddr == VEC_RESET)
      else $error("reset did not fetch reset vector");

   ext_prio_a: assert property (state_r == ST_IDLE && cpuIn.boundary && !cpuIn.trapExec && takeExt
      && !resetHit |=> cpuOut_r.vecAddr == VEC_EXT && prio_r == PRIO_EXT)
      else $error("external request not served first");

   entry_order_a: assert property (state_r == ST_STACK && cpuIn.stackDone && !resetHit
      |=> state_r == ST_MASK ##1 (cpuOut_r.globalMask && cpuOut_r.vecFetch))
      else $error("entry sequence out of order");

   ret_restore_a: assert property (cpuIn.retExec && !cpuIn.seiExec && !cpuIn.cliExec
      && state_r == ST_IDLE && !resetHit |=> cpuOut_r.globalMask == $past(cpuIn.retMask))
      else $error("return did not restore mask");

   trap_take_a: assert property (state_r == ST_IDLE && cpuIn.boundary && cpuIn.trapExec && !resetHit
      |=> state_r == ST_STACK && cpuOut_r.vecAddr == VEC_TRAP)
      else $error("software trap not taken");

   ext_block_a: assert property ($rose(cpuOut_r.stackReq) && cpuOut_r.vecAddr == VEC_EXT
      |-> $past(extEnable_r) && ($past(effMask) == 1'h0))
      else $error("external served while blocked");

   latch_clear_a: assert property (state_r == ST_MASK && cpuOut_r.vecAddr == VEC_EXT && !extEvent
      && !resetHit |=> !extLatch_r)
      else $error("latch not cleared at vector fetch");

   flag_clear_a: assert property (clrWrite && !extEvent |=> !extLatch_r && !readData_r[CTRL_CLR_BIT])
      else $error("clear write failed");

   edge_only_a: assert property (!LEVEL_SENS && !prevComb_r && !combN && !extLatch_r |=> !extLatch_r)
      else $error("held pin relatched in edge mode");

   port_hide_a: assert property (PORT_INT_EN && (|portIntPins) |-> !combN)
      else $error("port level did not hold request line");

   enable_reset_a: assert property (@(posedge clk) disable iff (1'b0) rst |=> extEnable_r)
      else $error("enable not set by reset");

   wait_answer_a: assert property ((avsIn.read || avsIn.write) && waitReq_r |=> !waitReq_r)
      else $error("bus answer late");

   no_preempt_a: assert property (state_r == ST_IDLE && cpuIn.boundary && effMask && !cpuIn.trapExec
      && !resetHit |=> !cpuOut_r.stackReq)
      else $error("masked request preempted a routine");

   stack_hold_a: assert property (state_r == ST_STACK && !cpuIn.stackDone && !resetHit
      |=> state_r == ST_STACK && cpuOut_r.stackReq && !cpuOut_r.vecFetch)
      else $error("stack request dropped early");

   vec_done_a: assert property (state_r == ST_VECTOR && cpuIn.vecDone && !resetHit
      |=> state_r == ST_IDLE && !cpuOut_r.vecFetch)
      else $error("vector fetch did not end");

   reset_entry_a: assert property (resetHit |=> cpuOut_r.resetEntry && prio_r == PRIO_RESET
      && cpuOut_r.globalMask && !cpuOut_r.stackReq)
      else $error("reset entry incomplete");

   timer_prio_a: assert property (state_r == ST_IDLE && cpuIn.boundary && !cpuIn.trapExec && !takeExt
      && takeSrc[0] && !resetHit |=> cpuOut_r.vecAddr == VEC_CTIMER && prio_r == PRIO_CTIMER)
      else $error("core timer not served next");

   trap_mask_a: assert property (state_r == ST_IDLE && cpuIn.boundary && cpuIn.trapExec
      && cpuOut_r.globalMask && !resetHit |=> cpuOut_r.stackReq && prio_r == PRIO_TRAP)
      else $error("masked software trap refused");

   edge_set_a: assert property (prevComb_r && !combN |=> extLatch_r)
      else $error("falling request line not latched");

   level_hold_a: assert property (LEVEL_SENS && !combN |=> extLatch_r)
      else $error("held level lost the request");

   pend_read_a: assert property (busAccept && avsIn.read && avsIn.address == ADDR_STATUS_CTRL
      |-> readData_r[CTRL_PEND_BIT] == $past(extLatch_r) && !readData_r[CTRL_CLR_BIT])
      else $error("status read wrong");

   wait_idle_a: assert property (!avsIn.read && !avsIn.write |=> waitReq_r)
      else $error("bus wait not restored");

   enable_write_a: assert property (busAccept && avsIn.write && avsIn.byteenable[0]
      && avsIn.address == ADDR_STATUS_CTRL |=> extEnable_r == $past(avsIn.writedata[CTRL_EN_BIT]))
      else $error("enable bit write lost");

   mask_set_a: assert property (state_r == ST_MASK && !resetHit
      |=> state_r == ST_VECTOR && cpuOut_r.globalMask && cpuOut_r.vecFetch)
      else $error("mask step did not start the fetch");

   cover_trap_c: cover property (state_r == ST_STACK && cpuOut_r.vecAddr == VEC_TRAP);
   cover_ext_c: cover property (state_r == ST_VECTOR && cpuOut_r.vecAddr == VEC_EXT);
   cover_reset_c: cover property (cpuOut_r.resetEntry);
   cover_clr_c: cover property (clrWrite && extLatch_r);
   cover_level_c: cover property (LEVEL_SENS && clrWrite && extEvent);

endmodule : ipei_ctrl

// ### rtl/ipei_pkg.sv
// ==========================================================
// interrupt controller package
package ipei_pkg;

   // ==========================================================
   // vector addresses (msb byte of each pair)
   localparam logic [15:0] VEC_RESET   = 16'h1ffe;
   localparam logic [15:0] VEC_TRAP    = 16'h1ffc;
   localparam logic [15:0] VEC_EXT     = 16'h1ffa;
   localparam logic [15:0] VEC_CTIMER  = 16'h1ff8;
   localparam logic [15:0] VEC_PTIMER  = 16'h1ff6;
   localparam logic [15:0] VEC_SERIAL  = 16'h1ff4;
   localparam logic [15:0] VEC_ANALOG  = 16'h1ff2;

   // ==========================================================
   // priorities, 1 highest, 0 for the software trap
   localparam logic [2:0]  PRIO_TRAP   = 3'h0;
   localparam logic [2:0]  PRIO_RESET  = 3'h1;
   localparam logic [2:0]  PRIO_EXT    = 3'h2;
   localparam logic [2:0]  PRIO_CTIMER = 3'h3;
   localparam logic [2:0]  PRIO_PTIMER = 3'h4;
   localparam logic [2:0]  PRIO_SERIAL = 3'h5;
   localparam logic [2:0]  PRIO_ANALOG = 3'h6;

   // ==========================================================
   // register map and fields
   localparam logic [3:0]  ADDR_STATUS_CTRL = 4'h0;
   localparam logic [3:0]  ADDR_SEQ_STATUS  = 4'h4;
   localparam int          CTRL_EN_BIT      = 7;
   localparam int          CTRL_PEND_BIT    = 3;
   localparam int          CTRL_CLR_BIT     = 1;
   localparam logic        CTRL_EN_RST      = 1'h1;
   localparam logic        MASK_RST         = 1'h1;
   localparam int          SEQ_STATE_LSB    = 0;
   localparam int          SEQ_PRIO_LSB     = 8;
   localparam int          SEQ_MASK_BIT     = 16;

   // ==========================================================
   // sources
   localparam int          RST_SRC_NUM      = 5;
   localparam int          PORT_PIN_NUM     = 4;

   // ==========================================================
   // types
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_STACK  = 4'h2,
      ST_MASK   = 4'h4,
      ST_VECTOR = 4'h8
   } ipei_state_type;

   typedef struct packed {
      logic boundary;
      logic trapExec;
      logic retExec;
      logic retMask;
      logic cliExec;
      logic seiExec;
      logic stackDone;
      logic vecDone;
   } ipei_cpu_in_type;

   typedef struct packed {
      logic        stackReq;
      logic        vecFetch;
      logic [15:0] vecAddr;
      logic        globalMask;
      logic        resetEntry;
   } ipei_cpu_out_type;

   typedef struct packed {
      logic [3:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } ipei_avs_in_type;

endpackage : ipei_pkg
